// File: bda_pkg.sv
/*
 * shared constants, state encoding and register record for the
 * decimal adjust unit.
 * assumes an 8-bit accumulator and an 8-bit data-memory address.
 */
package bda_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int NIB_W  = 4;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // nibble limit and correction values
    // ------------------------------------------------------------
    localparam logic [NIB_W-1:0]  NIB_MAX  = 4'h9;
    localparam logic [DATA_W-1:0] ADJ_NONE = 8'h00;
    localparam logic [DATA_W-1:0] ADJ_LOW  = 8'h06;
    localparam logic [DATA_W-1:0] ADJ_HIGH = 8'h60;
    localparam logic [DATA_W-1:0] ADJ_BOTH = 8'h66;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [0:0]
    {
        ST_IDLE   = 1'b0,
        ST_ADJUST = 1'b1
    } bda_state_t;

    typedef struct packed
    {
        bda_state_t          st;
        logic [DATA_W-1:0]   acc;
        logic                hc;
        logic                cy;
        logic [ADDR_W-1:0]   addr;
        logic                mem_we;
        logic [ADDR_W-1:0]   mem_addr;
        logic [DATA_W-1:0]   mem_data;
        logic                carry_we;
        logic                carry;
        logic [DATA_W-1:0]   adj;
        logic                busy;
        logic                done;
    } bda_regs_t;

    localparam bda_regs_t REGS_RST = '0;

    // ------------------------------------------------------------
    // nibble above nine, used for both halves
    // ------------------------------------------------------------
    function automatic logic nib_over_max(input logic [NIB_W-1:0] nib);
        nib_over_max = (nib > NIB_MAX);
    endfunction

endpackage

// File: bda_adjust.sv
/*
 * combinational decimal correction of one accumulator byte.
 * assumes operands are stable for the cycle they are used in.
 */
`timescale 1ns/1ns
module bda_adjust
(
    input  wire logic [bda_pkg::DATA_W-1:0] acc_i,
    input  wire logic                       half_carry_flag_i,
    input  wire logic                       carry_flag_i,
    output logic      [bda_pkg::DATA_W-1:0] result_o,
    output logic      [bda_pkg::DATA_W-1:0] adj_o,
    output logic                            carry_o
);

    logic                     low_fix;
    logic                     high_fix;
    logic [bda_pkg::DATA_W:0] low_sum;
    logic [bda_pkg::DATA_W:0] sum;

    // ------------------------------------------------------------
    // correction select and add
    // ------------------------------------------------------------
    always_comb
    begin
        low_fix  = bda_pkg::nib_over_max(acc_i[bda_pkg::NIB_W-1:0])
                   | half_carry_flag_i;                         // [RQ1]
        // upper test sees the byte after the low fix, so a low-nibble
        // overflow that lifts the upper half above nine still carries out of the byte
        low_sum  = {1'b0, acc_i}
                   + {1'b0, (low_fix ? bda_pkg::ADJ_LOW
                                     : bda_pkg::ADJ_NONE)};
        high_fix = bda_pkg::nib_over_max(
                       low_sum[bda_pkg::DATA_W-1:bda_pkg::NIB_W])
                   | low_sum[bda_pkg::DATA_W]
                   | carry_flag_i;                              // [RQ3] [RQ7]
        case ({high_fix, low_fix})                              // [RQ4]
            2'b01:   adj_o = bda_pkg::ADJ_LOW;
            2'b10:   adj_o = bda_pkg::ADJ_HIGH;
            2'b11:   adj_o = bda_pkg::ADJ_BOTH;
            default: adj_o = bda_pkg::ADJ_NONE;                 // [RQ2]
        endcase
        sum      = {1'b0, acc_i} + {1'b0, adj_o};
        result_o = sum[bda_pkg::DATA_W-1:0];
        // sticky: an incoming carry is never dropped
        carry_o  = carry_flag_i | sum[bda_pkg::DATA_W];        // [RQ7] [RQ8]
    end

endmodule

// File: bda_decimal_adjust.sv
/*
 * decimal adjust after addition: sequencer, operand capture and
 * data-memory / carry write-back for one decimal_adjust_op.
 * assumes the core drives the start strobe and operands on clk_sys_i
 * and applies the write strobes in the cycle they are shown.
 */
// Behaviour
// (RQ1) low nibble above nine or half carry set: add six to it
// (RQ2) otherwise the low nibble passes through unchanged
// (RQ3) high nibble above nine or carry set: add six to it
// (RQ4) correction is one of 0x00, 0x06, 0x60, 0x66 added to accumulator
// (RQ5) adjusted byte goes to the addressed data memory, not accumulator
// (RQ6) only carry may change; zero and half carry untouched
// (RQ7) carry set when the original decimal sum exceeds ninety-nine
// (RQ8) carry set on carry out of bit seven or if already set
`timescale 1ns/1ns
module bda_decimal_adjust
(
    input  wire logic                       clk_sys_i,
    input  wire logic                       arst_n_i,
    input  wire logic                       decimal_adjust_op_i,
    input  wire logic [bda_pkg::DATA_W-1:0] accumulator_reg_i,
    input  wire logic                       half_carry_flag_i,
    input  wire logic                       carry_flag_i,
    input  wire logic [bda_pkg::ADDR_W-1:0] mem_addr_i,
    output logic                            mem_we_o,
    output logic      [bda_pkg::ADDR_W-1:0] mem_addr_o,
    output logic      [bda_pkg::DATA_W-1:0] mem_data_o,
    output logic                            carry_we_o,
    output logic                            carry_o,
    output logic      [bda_pkg::DATA_W-1:0] adj_value_o,
    output logic                            busy_o,
    output logic                            done_o
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // correction datapath
    // ------------------------------------------------------------
    bda_pkg::bda_regs_t       regs_r;
    bda_pkg::bda_regs_t       regs_nxt;
    logic [bda_pkg::DATA_W-1:0] adj_result;
    logic [bda_pkg::DATA_W-1:0] adj_value;
    logic                       adj_carry;

    // works on captured operands so the core may move on after start
    bda_adjust u_adjust
    (
        .acc_i             (regs_r.acc),
        .half_carry_flag_i (regs_r.hc),
        .carry_flag_i      (regs_r.cy),
        .result_o          (adj_result),
        .adj_o             (adj_value),
        .carry_o           (adj_carry)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        regs_nxt          = regs_r;
        regs_nxt.mem_we   = 1'b0;
        regs_nxt.carry_we = 1'b0;
        regs_nxt.done     = 1'b0;
        case (regs_r.st)
            bda_pkg::ST_IDLE:
            begin
                // a strobe while busy is not seen: one op in flight
                if (decimal_adjust_op_i)
                begin
                    regs_nxt.acc  = accumulator_reg_i;
                    regs_nxt.hc   = half_carry_flag_i;
                    regs_nxt.cy   = carry_flag_i;
                    regs_nxt.addr = mem_addr_i;
                    regs_nxt.busy = 1'b1;
                    regs_nxt.st   = bda_pkg::ST_ADJUST;
                end
            end
            bda_pkg::ST_ADJUST:
            begin
                regs_nxt.mem_we   = 1'b1;                        // [RQ5]
                regs_nxt.mem_addr = regs_r.addr;                 // [RQ5]
                regs_nxt.mem_data = adj_result;                  // [RQ5]
                regs_nxt.adj      = adj_value;                   // [RQ4]
                // only the carry write port exists; other flags hold
                regs_nxt.carry_we = 1'b1;                        // [RQ6]
                regs_nxt.carry    = adj_carry;                   // [RQ7] [RQ8]
                regs_nxt.done     = 1'b1;
                regs_nxt.busy     = 1'b0;
                regs_nxt.st       = bda_pkg::ST_IDLE;
            end
            default:
            begin
                regs_nxt = bda_pkg::REGS_RST;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            regs_r <= bda_pkg::REGS_RST;
        end
        else
        begin
            regs_r <= regs_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from the state record
    // ------------------------------------------------------------
    assign mem_we_o    = regs_r.mem_we;
    assign mem_addr_o  = regs_r.mem_addr;
    assign mem_data_o  = regs_r.mem_data;
    assign carry_we_o  = regs_r.carry_we;
    assign carry_o     = regs_r.carry;
    assign adj_value_o = regs_r.adj;
    assign busy_o      = regs_r.busy;
    assign done_o      = regs_r.done;

endmodule

// File: bda_checker.sv
/* assertions on the ports of the decimal adjust unit.
   assumes a bind onto bda_decimal_adjust, one clock domain. */
`timescale 1ns/1ns
module bda_checker
(
    input wire logic       clk_sys_i,
    input wire logic       arst_n_i,
    input wire logic       decimal_adjust_op_i,
    input wire logic [7:0] accumulator_reg_i,
    input wire logic       half_carry_flag_i,
    input wire logic       carry_flag_i,
    input wire logic [7:0] mem_addr_i,
    input wire logic       mem_we_o,
    input wire logic [7:0] mem_addr_o,
    input wire logic [7:0] mem_data_o,
    input wire logic       carry_we_o,
    input wire logic       carry_o,
    input wire logic [7:0] adj_value_o,
    input wire logic       busy_o,
    input wire logic       done_o
);
    // ------------------------------------------------------------
    // start to write-back
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_take;
        decimal_adjust_op_i && !busy_o;
    endsequence
    sequence s_done;
        done_o && mem_we_o && carry_we_o;
    endsequence
    a_answer_two: assert property (
        s_take |=> busy_o ##1 s_done) else $error("answer late");
    a_strobe_single: assert property (
        done_o |=> !mem_we_o && !carry_we_o) else $error("strobe long");
    a_adj_codes: assert property (
        done_o |-> adj_value_o inside {8'h00, 8'h06, 8'h60, 8'h66})
        else $error("bad correction");
    a_data_sum: assert property (
        done_o |-> mem_data_o == 8'($past(accumulator_reg_i, 2) + adj_value_o))
        else $error("bad sum");
    a_addr_follow: assert property (
        done_o |-> mem_addr_o == $past(mem_addr_i, 2)) else $error("bad addr");
    a_low_fix: assert property (
        s_take ##0 (accumulator_reg_i[3:0] > 4'h9 || half_carry_flag_i)
        |-> ##2 adj_value_o[3:0] == 4'h6) else $error("low fix missing");
    a_low_keep: assert property (
        done_o && adj_value_o[3:0] == 4'h0 |->
        ((mem_data_o ^ $past(accumulator_reg_i, 2)) & 8'h0f) == 8'h00)
        else $error("low nibble changed");
    a_high_fix: assert property (
        s_take ##0 (accumulator_reg_i[7:4] > 4'h9 || carry_flag_i)
        |-> ##2 adj_value_o[7:4] == 4'h6) else $error("high fix missing");
    a_high_spill: assert property (
        s_take ##0 (accumulator_reg_i[3:0] > 4'h9 &&
                    accumulator_reg_i[7:4] == 4'h9)
        |-> ##2 adj_value_o == 8'h66 && carry_o) else $error("spill lost");
    a_carry_keep: assert property (
        s_take ##0 carry_flag_i |-> ##2 carry_o) else $error("carry lost");
endmodule

bind bda_decimal_adjust bda_checker bda_checker_i
(
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .decimal_adjust_op_i(decimal_adjust_op_i),
    .accumulator_reg_i(accumulator_reg_i),
    .half_carry_flag_i(half_carry_flag_i), .carry_flag_i(carry_flag_i),
    .mem_addr_i(mem_addr_i), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_data_o(mem_data_o), .carry_we_o(carry_we_o), .carry_o(carry_o),
    .adj_value_o(adj_value_o), .busy_o(busy_o), .done_o(done_o)
);

// File: bda_core_model.sv
/* core-side model: data memory and carry flag.
   assumes write strobes from the decimal adjust unit. */
`timescale 1ns/1ns
module bda_core_model
(
    input  wire logic       clk_sys_i,
    input  wire logic       mem_we_i,
    input  wire logic [7:0] mem_addr_i,
    input  wire logic [7:0] mem_data_i,
    input  wire logic       carry_we_i,
    input  wire logic       carry_i,
    input  wire logic [7:0] rd_addr_i,
    output logic      [7:0] rd_data_o,
    output logic            carry_flag_o
);
    logic [7:0] mem_r [256];
    logic       carry_r = 1'b0;
    // only carry is written back; zero and half carry live elsewhere
    always @(posedge clk_sys_i)
    begin
        if (mem_we_i)
            mem_r[mem_addr_i] <= mem_data_i;
        if (carry_we_i)
            carry_r <= carry_i;
    end
    assign rd_data_o    = mem_r[rd_addr_i];
    assign carry_flag_o = carry_r;
endmodule

// File: tb.sv
/* bench: table of decimal adjust cases, then refusal and reset.
   assumes the fixed two-edge answer of the unit. */
`timescale 1ns/1ns
module tb;
    typedef struct packed
    {
        logic [7:0] acc;
        logic       hc;
        logic       cy;
        logic [7:0] adj;
        logic [7:0] data;
        logic       co;
    } bda_row_t;
    // ------------------------------------------------------------
    // cases: acc hc cy -> correction data carry
    // ------------------------------------------------------------
    bda_row_t   rows [8] = '{
        '{8'h9a, 1'b0, 1'b0, 8'h66, 8'h00, 1'b1},
        '{8'ha5, 1'b0, 1'b0, 8'h60, 8'h05, 1'b1},
        '{8'h99, 1'b1, 1'b0, 8'h06, 8'h9f, 1'b0},
        '{8'h00, 1'b0, 1'b1, 8'h60, 8'h60, 1'b1},
        '{8'h12, 1'b0, 1'b0, 8'h00, 8'h12, 1'b0},
        '{8'hff, 1'b0, 1'b0, 8'h66, 8'h65, 1'b1},
        '{8'h45, 1'b1, 1'b1, 8'h66, 8'hab, 1'b1},
        '{8'ha0, 1'b0, 1'b0, 8'h60, 8'h00, 1'b1}};
    logic       clk_sys_i = 0;
    logic       arst_n_i  = 0;
    logic       op = 0, hc = 0, cy = 0, mem_we_o, carry_we_o, carry_o;
    logic       busy_o, done_o, carry_flag;
    logic [7:0] acc = 8'h00, addr = 8'h00, rd_addr = 8'h00;
    logic [7:0] mem_addr_o, mem_data_o, adj_value_o, rd_data;
    int         failures = 0, checked = 0, n;
    bda_decimal_adjust bda_decimal_adjust_i (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .decimal_adjust_op_i(op),
        .accumulator_reg_i(acc), .half_carry_flag_i(hc), .carry_flag_i(cy),
        .mem_addr_i(addr), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_data_o(mem_data_o), .carry_we_o(carry_we_o), .carry_o(carry_o),
        .adj_value_o(adj_value_o), .busy_o(busy_o), .done_o(done_o));
    bda_core_model bda_core_model_i (.clk_sys_i(clk_sys_i),
        .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_data_i(mem_data_o),
        .carry_we_i(carry_we_o), .carry_i(carry_o), .rd_addr_i(rd_addr),
        .rd_data_o(rd_data), .carry_flag_o(carry_flag));
    initial forever #50 clk_sys_i = ~clk_sys_i;
    task automatic summarize();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one op, called at a falling edge, polls done under a bound
    task automatic run(input bda_row_t r, input logic [7:0] a);
        {acc, hc, cy, addr, op} = {r.acc, r.hc, r.cy, a, 1'b1};
        @(negedge clk_sys_i);
        op = 0;
        for (n = 0; n < 4 && done_o !== 1'b1; n++)
            @(negedge clk_sys_i);
        if (n == 4)
        begin
            failures++; // bounded wait ran out, verdict at the end
            return;
        end
        check(adj_value_o, r.adj);
        check(mem_data_o, r.data);
        check(mem_addr_o, a);
        check({7'h0, carry_o}, {7'h0, r.co});
        rd_addr = a;
        @(negedge clk_sys_i);
        check(rd_data, r.data);
        check({7'h0, carry_flag}, {7'h0, r.co});
    endtask
    initial
    begin
        repeat (8) @(negedge clk_sys_i);
        arst_n_i = 1;
        repeat (3) @(negedge clk_sys_i);
        foreach (rows[i])
            run(rows[i], 8'(i * 17));
        $display("table done");
        op = 1; // held over two edges: second start is refused
        @(negedge clk_sys_i);
        @(negedge clk_sys_i);
        op = 0;
        n = int'(done_o === 1'b1);
        repeat (4) @(negedge clk_sys_i) n += int'(done_o === 1'b1);
        check(8'(n), 8'h01);
        $display("refusal done");
        arst_n_i = 0;
        @(negedge clk_sys_i);
        check({3'h0, busy_o, done_o, mem_we_o, carry_we_o, carry_o},
              8'h00);
        check(mem_data_o, 8'h00);
        check(adj_value_o, 8'h00);
        arst_n_i = 1;
        repeat (3) @(negedge clk_sys_i);
        run(rows[5], 8'hc3);
        $display("reset done");
        summarize();
    end
endmodule
